/* File: core/sse_status_top.sv */
// Line and modem status emulation behind the host I/O register port
`timescale 1ns/1ps
`include "sse_defs.svh"
module sse_status_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire sse_pkg::sse_addr_t io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire sse_pkg::sse_byte_t io_wdata_i,
    output sse_pkg::sse_byte_t io_rdata_o,
    output logic io_rvalid_o,
    input wire logic gpib_srq_n_i,
    input wire logic srq_feature_off_i,
    input wire logic tx_holding_empty_i,
    input wire logic rx_store_i,
    input wire sse_pkg::sse_byte_t rx_byte_i,
    output logic receive_byte_ready_o,
    output logic clear_to_send_o,
    output sse_pkg::sse_mctrl_t modem_ctrl_o
);
    logic srq_n_lvl;
    logic srq_off_lvl;
    logic srq_active;
    logic rx_ready;
    sse_pkg::sse_byte_t rx_data;

    logic rd_rx;
    logic rd_lts;
    logic rd_mls;
    logic wr_mctrl;

    logic parity_error_flag_r;
    logic parity_error_flag_nxt;
    sse_pkg::sse_mctrl_t mctrl_r;
    sse_pkg::sse_mctrl_t mctrl_nxt;
    sse_pkg::sse_byte_t rdata_r;
    sse_pkg::sse_byte_t rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    logic cts_and;
    sse_pkg::sse_byte_t lts_view;
    sse_pkg::sse_byte_t mls_view;

    function automatic logic hit(input sse_pkg::sse_addr_t a, input sse_pkg::sse_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // Pins from the instrument side and the board switch cross in here
    sse_sync3 #(
        .RST_VAL(1'h1)
    ) u_srq_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(gpib_srq_n_i),
        .level_o(srq_n_lvl)
    );

    sse_sync3 #(
        .RST_VAL(1'h0)
    ) u_off_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(srq_feature_off_i),
        .level_o(srq_off_lvl)
    );

    assign rd_rx = io_rd_i & hit(io_addr_i, `SSE_OFS_RX_DATA);
    assign rd_lts = io_rd_i & hit(io_addr_i, `SSE_OFS_LINE_TRANSFER_STATUS);
    assign rd_mls = io_rd_i & hit(io_addr_i, `SSE_OFS_MODEM_LINE_STATUS);
    // Only modem control takes writes; status offsets drop them
    assign wr_mctrl = io_wr_i & hit(io_addr_i, `SSE_OFS_MODEM_CTRL);

    sse_rx_hold u_rx_hold (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .store_i(rx_store_i),
        .byte_i(rx_byte_i),
        .take_i(rd_rx),
        .byte_o(rx_data),
        .ready_o(rx_ready)
    );

    assign srq_active = ~srq_n_lvl;
    assign cts_and = mctrl_r[`SSE_MCTRL_TERM_READY_BIT] & mctrl_r[`SSE_MCTRL_REQ_SEND_BIT];

    always_comb begin
        // Set beats the clearing read, so a held request keeps the flag set through the read
        parity_error_flag_nxt = srq_active | (parity_error_flag_r & ~rd_lts);
        if (srq_off_lvl) begin
            parity_error_flag_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            parity_error_flag_r <= 1'h0;
        end else begin
            parity_error_flag_r <= parity_error_flag_nxt;
        end
    end

    always_comb begin
        mctrl_nxt = mctrl_r;
        if (wr_mctrl) begin
            mctrl_nxt = io_wdata_i[`SSE_MCTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mctrl_r <= `SSE_MCTRL_RESET;
        end else begin
            mctrl_r <= mctrl_nxt;
        end
    end

    always_comb begin
        lts_view = 8'h00;
        lts_view[`SSE_LTS_READY_BIT] = rx_ready;
        lts_view[`SSE_LTS_OVERRUN_BIT] = 1'h0;
        // Switch gates the read view too, covering the cycle before the flag register clears
        lts_view[`SSE_LTS_PARITY_BIT] = parity_error_flag_r & ~srq_off_lvl;
        lts_view[`SSE_LTS_FRAMING_BIT] = 1'h0;
        lts_view[`SSE_LTS_BREAK_BIT] = 1'h0;
        // No shift stage on this board, so both empty bits track the holding register
        lts_view[`SSE_LTS_THR_EMPTY_BIT] = tx_holding_empty_i;
        lts_view[`SSE_LTS_TX_EMPTY_BIT] = tx_holding_empty_i;
    end

    always_comb begin
        mls_view = 8'h00;
        mls_view[`SSE_MLS_CTS_DELTA_BIT] = cts_and;
        mls_view[`SSE_MLS_DSR_DELTA_BIT] = 1'h0;
        mls_view[`SSE_MLS_RING_EDGE_BIT] = 1'h0;
        mls_view[`SSE_MLS_CARRIER_DELTA_BIT] = 1'h0;
        mls_view[`SSE_MLS_CTS_BIT] = cts_and;
        mls_view[`SSE_MLS_DSR_BIT] = 1'h1;
        mls_view[`SSE_MLS_RING_BIT] = 1'h0;
        mls_view[`SSE_MLS_CARRIER_BIT] = 1'h0;
    end

    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = io_rd_i;
        if (io_rd_i) begin
            // Unlisted offsets read as zero
            rdata_nxt = 8'h00;
            if (hit(io_addr_i, `SSE_OFS_RX_DATA)) begin
                rdata_nxt = rx_data;
            end else if (hit(io_addr_i, `SSE_OFS_MODEM_CTRL)) begin
                rdata_nxt = {3'h0, mctrl_r};
            end else if (hit(io_addr_i, `SSE_OFS_LINE_TRANSFER_STATUS)) begin
                rdata_nxt = lts_view;
            end else if (hit(io_addr_i, `SSE_OFS_MODEM_LINE_STATUS)) begin
                rdata_nxt = mls_view;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'h0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign io_rdata_o = rdata_r;
    assign io_rvalid_o = rvalid_r;
    assign receive_byte_ready_o = rx_ready;
    assign clear_to_send_o = cts_and;
    assign modem_ctrl_o = mctrl_r;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_lts_read;
        io_rd_i && hit(io_addr_i, `SSE_OFS_LINE_TRANSFER_STATUS);
    endsequence

    sequence s_mls_read;
        io_rd_i && hit(io_addr_i, `SSE_OFS_MODEM_LINE_STATUS);
    endsequence

    property p_lts_fixed_zero;
        s_lts_read |=> io_rvalid_o && !io_rdata_o[`SSE_LTS_FRAMING_BIT]
            && !io_rdata_o[`SSE_LTS_OVERRUN_BIT];
    endproperty
    a_lts_fixed_zero: assert property (p_lts_fixed_zero) else $error("lts fixed bits");

    property p_overrun_zero_full;
        rd_lts && rx_ready && rx_store_i |=> !io_rdata_o[`SSE_LTS_OVERRUN_BIT];
    endproperty
    a_overrun_zero_full: assert property (p_overrun_zero_full) else $error("overrun set");

    property p_srq_sets;
        srq_active && !srq_off_lvl |=> parity_error_flag_r;
    endproperty
    a_srq_sets: assert property (p_srq_sets) else $error("srq not reported");

    property p_srq_off;
        srq_off_lvl |=> !parity_error_flag_r ##1 !parity_error_flag_r || !srq_off_lvl;
    endproperty
    a_srq_off: assert property (p_srq_off) else $error("parity set while disabled");

    property p_lts_read_clears;
        rd_lts && !srq_active |=> !parity_error_flag_r;
    endproperty
    a_lts_read_clears: assert property (p_lts_read_clears) else $error("parity not cleared");

    property p_parity_rearm;
        rd_lts && srq_active && !srq_off_lvl |=> parity_error_flag_r;
    endproperty
    a_parity_rearm: assert property (p_parity_rearm) else $error("parity lost");

    property p_parity_view;
        s_lts_read |=> io_rdata_o[`SSE_LTS_PARITY_BIT]
            == $past(parity_error_flag_r && !srq_off_lvl);
    endproperty
    a_parity_view: assert property (p_parity_view) else $error("parity view wrong");

    property p_ready_view;
        rx_store_i ##1 s_lts_read |=> io_rdata_o[`SSE_LTS_READY_BIT];
    endproperty
    a_ready_view: assert property (p_ready_view) else $error("ready not shown");

    property p_rx_read_clears;
        io_rd_i && hit(io_addr_i, `SSE_OFS_RX_DATA) && !rx_store_i |=> !receive_byte_ready_o;
    endproperty
    a_rx_read_clears: assert property (p_rx_read_clears) else $error("ready not cleared");

    property p_status_writes_dropped;
        io_wr_i && !hit(io_addr_i, `SSE_OFS_MODEM_CTRL) |=> $stable(mctrl_r);
    endproperty
    a_status_writes_dropped: assert property (p_status_writes_dropped) else $error("ro written");

    property p_mls_fixed;
        s_mls_read |=> io_rdata_o[`SSE_MLS_CARRIER_BIT:`SSE_MLS_DSR_BIT] == 3'h1
            && io_rdata_o[`SSE_MLS_CARRIER_DELTA_BIT:`SSE_MLS_DSR_DELTA_BIT] == 3'h0;
    endproperty
    a_mls_fixed: assert property (p_mls_fixed) else $error("modem fixed bits");

    property p_cts_follows;
        s_mls_read |=> io_rdata_o[`SSE_MLS_CTS_BIT] == ($past(mctrl_r[0]) && $past(mctrl_r[1]))
            && io_rdata_o[`SSE_MLS_CTS_DELTA_BIT] == io_rdata_o[`SSE_MLS_CTS_BIT];
    endproperty
    a_cts_follows: assert property (p_cts_follows) else $error("cts mismatch");

    property p_mctrl_write;
        wr_mctrl |=> clear_to_send_o == ($past(io_wdata_i[0]) && $past(io_wdata_i[1]));
    endproperty
    a_mctrl_write: assert property (p_mctrl_write) else $error("cts write path");

    property p_rvalid_pulse;
        io_rvalid_o == $past(io_rd_i);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer timing");

    property p_rdata_hold;
        !io_rd_i |=> $stable(io_rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    property p_mctrl_read_back;
        io_rd_i && hit(io_addr_i, `SSE_OFS_MODEM_CTRL)
            |=> io_rdata_o == {3'h0, $past(mctrl_r)};
    endproperty
    a_mctrl_read_back: assert property (p_mctrl_read_back) else $error("modem ctrl read");

    property p_rx_read_data;
        rd_rx |=> io_rdata_o == $past(rx_data);
    endproperty
    a_rx_read_data: assert property (p_rx_read_data) else $error("rx byte read");

    property p_unmapped_zero;
        io_rd_i && !hit(io_addr_i, `SSE_OFS_RX_DATA) && !hit(io_addr_i, `SSE_OFS_MODEM_CTRL)
            && !rd_lts && !rd_mls |=> io_rdata_o == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");

    property p_lts_spare_bits;
        rd_lts |=> io_rdata_o[7:4]
            == {1'h0, $past(tx_holding_empty_i), $past(tx_holding_empty_i), 1'h0};
    endproperty
    a_lts_spare_bits: assert property (p_lts_spare_bits) else $error("lts upper bits");

    property p_off_view;
        rd_lts && srq_off_lvl |=> !io_rdata_o[`SSE_LTS_PARITY_BIT];
    endproperty
    a_off_view: assert property (p_off_view) else $error("parity shown while disabled");

    property p_mctrl_hold;
        !wr_mctrl |=> $stable(mctrl_r);
    endproperty
    a_mctrl_hold: assert property (p_mctrl_hold) else $error("modem ctrl moved");

    c_srq_read: cover property (srq_active ##[1:4] s_lts_read);
    c_rx_cycle: cover property (rx_store_i ##[1:8] (io_rd_i && io_addr_i == 3'h0));
    c_cts_on: cover property (wr_mctrl ##1 clear_to_send_o ##1 s_mls_read);
    c_set_wins: cover property (rx_store_i && rd_rx);
    c_srq_masked: cover property (srq_active && srq_off_lvl ##1 s_lts_read);
endmodule

/* File: core/sse_defs.svh */
// Offsets, bit positions and reset values for the serial status emulation block
// What this block does
// - Line status framing error bit 3 always reads zero.
// - Line status overrun bit 1 always reads zero; bytes never flagged overrun.
// - Line status parity bit 2 sets while the instrument service request is asserted.
// - Service request disable switch forces parity bit to zero.
// - Reading line status clears the parity bit unless the service request is still asserted.
// - Data ready bit 0 sets once a byte sits in the receive buffer.
// - Reading the receive buffer clears data ready unless a byte is stored in the same cycle.
// - Modem status at offset 6 is read-only; writes change nothing.
// - Carrier detect bit 7 of modem status always reads zero.
// - Ring indicator bit 6 of modem status always reads zero.
// - Data set ready bit 5 of modem status always reads one.
// - Clear-to-send bit 4 equals terminal ready AND request to send.
// - Clear-to-send delta bit 0 equals the same AND, not a change flag.
// - Carrier detect delta bit 3 always reads zero.
// - Ring trailing edge bit 2 always reads zero.
// - Data set ready delta bit 1 always reads zero.
// - Modem control bit 1 is request to send, bit 0 terminal ready.
// - Line status register is read-only; writes change nothing.
// - Byte accepted from the instrument is stored and sets data ready.
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

`define SSE_OFS_RX_DATA 3'h0
`define SSE_OFS_MODEM_CTRL 3'h4
`define SSE_OFS_LINE_TRANSFER_STATUS 3'h5
`define SSE_OFS_MODEM_LINE_STATUS 3'h6

`define SSE_LTS_READY_BIT 0
`define SSE_LTS_OVERRUN_BIT 1
`define SSE_LTS_PARITY_BIT 2
`define SSE_LTS_FRAMING_BIT 3
`define SSE_LTS_BREAK_BIT 4
`define SSE_LTS_THR_EMPTY_BIT 5
`define SSE_LTS_TX_EMPTY_BIT 6

`define SSE_MLS_CTS_DELTA_BIT 0
`define SSE_MLS_DSR_DELTA_BIT 1
`define SSE_MLS_RING_EDGE_BIT 2
`define SSE_MLS_CARRIER_DELTA_BIT 3
`define SSE_MLS_CTS_BIT 4
`define SSE_MLS_DSR_BIT 5
`define SSE_MLS_RING_BIT 6
`define SSE_MLS_CARRIER_BIT 7

`define SSE_MCTRL_TERM_READY_BIT 0
`define SSE_MCTRL_REQ_SEND_BIT 1
`define SSE_MCTRL_WIDTH 5
`define SSE_MCTRL_RESET 5'h00
`define SSE_BYTE_RESET 8'h00

`endif

/* File: core/sse_pkg.sv */
// Shared types for the serial status emulation block
package sse_pkg;
    typedef logic [2:0] sse_addr_t;
    typedef logic [7:0] sse_byte_t;
    typedef logic [4:0] sse_mctrl_t;
endpackage

/* File: core/sse_sync3.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module sse_sync3 #(
    parameter logic RST_VAL = 1'h0
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic level_nxt;

    // Stage one feeds only stage two; the filter looks at stages two and three
    always_comb begin
        level_nxt = level_r;
        if (s2_r == s3_r) begin
            level_nxt = s2_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level_r <= RST_VAL;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;
endmodule

/* File: core/sse_rx_hold.sv */
// Receive buffer byte and its ready flag
`timescale 1ns/1ps
`include "sse_defs.svh"
module sse_rx_hold (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic store_i,
    input wire sse_pkg::sse_byte_t byte_i,
    input wire logic take_i,
    output sse_pkg::sse_byte_t byte_o,
    output logic ready_o
);
    sse_pkg::sse_byte_t data_r;
    sse_pkg::sse_byte_t data_nxt;
    logic ready_r;
    logic ready_nxt;

    always_comb begin
        data_nxt = data_r;
        if (store_i) begin
            data_nxt = byte_i;
        end
        // Store beats take so a byte landing during a read is still reported
        ready_nxt = store_i | (ready_r & ~take_i);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_r <= `SSE_BYTE_RESET;
            ready_r <= 1'h0;
        end else begin
            data_r <= data_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign byte_o = data_r;
    assign ready_o = ready_r;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_store_sets;
        store_i |=> ready_r && (data_r == $past(byte_i));
    endproperty
    a_store_sets: assert property (p_store_sets) else $error("store lost");

    property p_take_clears;
        take_i && !store_i |=> !ready_r;
    endproperty
    a_take_clears: assert property (p_take_clears) else $error("take did not clear");
endmodule

/* File: testbench/sse_instr_model.sv */
// Instrument-side model: service request pin and accepted bytes
`timescale 1ns/1ps
module sse_instr_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic srq_on_i,
    input wire logic send_i,
    input wire sse_pkg::sse_byte_t send_byte_i,
    output logic gpib_srq_n_o,
    output logic rx_store_o,
    output sse_pkg::sse_byte_t rx_byte_o
);
    // Pulled-up line, so released reads high
    assign gpib_srq_n_o = srq_on_i ? 1'h0 : 1'h1;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_store_o <= 1'h0;
            rx_byte_o <= 8'h00;
        end else begin
            rx_store_o <= send_i;
            // Idle data toggles so stale bytes never look valid
            rx_byte_o <= send_i ? send_byte_i : ~rx_byte_o;
        end
    end
endmodule

/* File: testbench/serial_status_emulation_tb_top.sv */
// Self-checking bench for the serial status emulation block
`timescale 1ns/1ps
module serial_status_emulation_tb_top;
    logic clk_sys_i = 1'h0;
    logic rst_n_i = 1'h0;
    sse_pkg::sse_addr_t addr = 3'h0;
    logic rd_s = 1'h0;
    logic wr_s = 1'h0;
    sse_pkg::sse_byte_t wdata = 8'h00;
    sse_pkg::sse_byte_t rdata;
    logic rvalid;
    logic srq_n;
    logic srq_off = 1'h0;
    logic thre = 1'h1;
    logic store;
    sse_pkg::sse_byte_t rx_byte;
    logic ready;
    logic cts;
    sse_pkg::sse_mctrl_t mctrl;
    logic srq_on = 1'h0;
    logic send = 1'h0;
    sse_pkg::sse_byte_t send_byte = 8'h00;
    int fail_count = 0;
    int checked = 0;
    sse_pkg::sse_byte_t rd;
    sse_pkg::sse_byte_t b0;
    sse_pkg::sse_byte_t b1;
    sse_pkg::sse_mctrl_t mc;
    sse_pkg::sse_addr_t unm[4] = '{3'h1, 3'h2, 3'h3, 3'h7};

    always #4 clk_sys_i = ~clk_sys_i;

    sse_status_top u_sse_status_top (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .io_addr_i(addr),
        .io_rd_i(rd_s),
        .io_wr_i(wr_s),
        .io_wdata_i(wdata),
        .io_rdata_o(rdata),
        .io_rvalid_o(rvalid),
        .gpib_srq_n_i(srq_n),
        .srq_feature_off_i(srq_off),
        .tx_holding_empty_i(thre),
        .rx_store_i(store),
        .rx_byte_i(rx_byte),
        .receive_byte_ready_o(ready),
        .clear_to_send_o(cts),
        .modem_ctrl_o(mctrl)
    );

    sse_instr_model u_sse_instr_model (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .srq_on_i(srq_on),
        .send_i(send),
        .send_byte_i(send_byte),
        .gpib_srq_n_o(srq_n),
        .rx_store_o(store),
        .rx_byte_o(rx_byte)
    );

    function automatic sse_pkg::sse_byte_t exp_lts(logic rdy, logic par, logic emp);
        return {1'h0, emp, emp, 2'h0, par, 1'h0, rdy};
    endfunction

    function automatic sse_pkg::sse_byte_t exp_mls(sse_pkg::sse_mctrl_t m);
        return {2'h0, 1'h1, m[0] & m[1], 3'h0, m[0] & m[1]};
    endfunction

    task automatic cmp_byte(sse_pkg::sse_byte_t got, sse_pkg::sse_byte_t exp, string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(logic got, logic exp, string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // One idle cycle between requests keeps strobe edges apart
    task automatic io_read(sse_pkg::sse_addr_t a, output sse_pkg::sse_byte_t d);
        @(posedge clk_sys_i);
        #1;
        addr = a;
        thre = 1'($urandom);
        rd_s = 1'h1;
        @(posedge clk_sys_i);
        #1;
        rd_s = 1'h0;
        cmp_bit(rvalid, 1'h1, "read answer");
        d = rdata;
    endtask

    task automatic io_write(sse_pkg::sse_addr_t a, sse_pkg::sse_byte_t v);
        @(posedge clk_sys_i);
        #1;
        addr = a;
        wdata = v;
        wr_s = 1'h1;
        @(posedge clk_sys_i);
        #1;
        wr_s = 1'h0;
    endtask

    task automatic instr_send(sse_pkg::sse_byte_t v);
        @(posedge clk_sys_i);
        #1;
        send_byte = v;
        send = 1'h1;
        @(posedge clk_sys_i);
        #1;
        send = 1'h0;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(8 * 4000);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        report_and_stop();
    end

    initial begin
        void'($urandom(91));
        idle(2);
        #1 rst_n_i = 1'h1;
        io_read(3'h6, rd);
        cmp_byte(rd, exp_mls(5'h00), "modem status reset");
        cmp_bit(ready, 1'h0, "ready reset");
        for (int i = 0; i < 4; i++) begin
            mc = {3'($urandom), 2'(i)};
            io_write(3'h4, {3'($urandom), mc});
            cmp_byte({3'h0, mctrl}, {3'h0, mc}, "modem ctrl");
            cmp_bit(cts, mc[0] & mc[1], "cts pin");
            io_read(3'h4, rd);
            cmp_byte(rd, {3'h0, mc}, "modem ctrl read");
            io_write(3'h6, 8'($urandom));
            io_read(3'h6, rd);
            cmp_byte(rd, exp_mls(mc), "modem status");
        end
        io_write(3'h5, 8'hFF);
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h0, thre), "line status");
        b0 = 8'($urandom);
        instr_send(b0);
        cmp_bit(ready, 1'h1, "ready after store");
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h1, 1'h0, thre), "data ready");
        io_read(3'h0, rd);
        cmp_byte(rd, b0, "rx byte");
        cmp_bit(ready, 1'h0, "ready after read");
        b0 = 8'($urandom);
        b1 = ~b0;
        instr_send(b0);
        instr_send(b1);
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h1, 1'h0, thre), "no overrun");
        io_read(3'h0, rd);
        cmp_byte(rd, b1, "newest byte");
        // Store lands on the same edge as the buffer read
        instr_send(b0);
        send_byte = b1;
        send = 1'h1;
        @(posedge clk_sys_i);
        #1;
        send = 1'h0;
        addr = 3'h0;
        rd_s = 1'h1;
        @(posedge clk_sys_i);
        #1;
        rd_s = 1'h0;
        cmp_byte(rdata, b0, "byte before store");
        @(posedge clk_sys_i);
        #1;
        cmp_bit(ready, 1'h1, "store beats clear");
        io_read(3'h0, rd);
        cmp_byte(rd, b1, "kept byte");
        srq_on = 1'h1;
        idle(8);
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h1, thre), "srq flag");
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h1, thre), "srq reset again");
        srq_on = 1'h0;
        idle(8);
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h1, thre), "flag held");
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h0, thre), "flag cleared");
        srq_off = 1'h1;
        srq_on = 1'h1;
        idle(8);
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h0, thre), "srq masked");
        srq_on = 1'h0;
        idle(8);
        srq_off = 1'h0;
        idle(8);
        io_read(3'h5, rd);
        cmp_byte(rd, exp_lts(1'h0, 1'h0, thre), "never set");
        foreach (unm[k]) begin
            io_read(unm[k], rd);
            cmp_byte(rd, 8'h00, "unmapped read");
        end
        report_and_stop();
    end
endmodule
